// ---- include/amp_prot_pkg.sv ----
package amp_prot_pkg;

   localparam int NUM_STAGES = 4;
   localparam int NUM_SENSE  = 3;

   // Output configuration modes, strap code {hi, lo}
   typedef enum logic [1:0] {
      MODE_FB2      = 2'b00,
      MODE_FB2_LINE = 2'b01,
      MODE_HB2_SUB  = 2'b10,
      MODE_HB4      = 2'b11
   } out_mode_t;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT  = 2'b01,
      ST_RUN   = 2'b10,
      ST_UVLO  = 2'b11
   } run_state_t;

   // Overcurrent detector samples for one stage
   typedef struct packed {
      logic oc_low;
      logic oc_high;
   } oc_sense_t;

   // Persistence (hysteresis) filter length in cycles for overcurrent detectors
   localparam int OC_FILTER_NS     = 100;
   localparam int CLK_PERIOD_NS    = 20;
   localparam int OC_FILTER_CYCLES = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Gain reduction step timing
   localparam int AGC_HOLD_US      = 1000;
   localparam int AGC_HOLD_CYCLES  = AGC_HOLD_US * 1000 / CLK_PERIOD_NS;
   localparam int AGC_PEAKS_TO_STEP = 4;
   localparam logic [3:0] AGC_MAX_STEP     = 4'hF;
   localparam logic [3:0] AGC_THERMAL_STEP = 4'h4;

endpackage : amp_prot_pkg

// ---- logic/oc_detector.sv ----
`timescale 1ns/1ns
// One stage: filtered low/high overcurrent with latched high-threshold shutdown
module oc_detector #(
   parameter int FILTER_CYCLES = amp_prot_pkg::OC_FILTER_CYCLES
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    sys_rst_i,
   input  wire amp_prot_pkg::oc_sense_t sense_i,
   input  wire logic                    pwm_on_i,
   output logic                         fault_low_o,
   output logic                         shutdown_o
);
   localparam int CW = $clog2(FILTER_CYCLES + 1);

   logic [CW-1:0] low_cnt_reg;
   logic [CW-1:0] high_cnt_reg;
   logic          low_act_reg;
   logic          latch_reg;

   // Detection must persist; switching spikes shorter than the filter are ignored
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !sense_i.oc_low) begin
         low_cnt_reg <= '0;
         low_act_reg <= 1'b0;
      end else if (low_cnt_reg == CW'(FILTER_CYCLES)) begin
         low_act_reg <= 1'b1;
      end else begin
         low_cnt_reg <= low_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !sense_i.oc_high) begin
         high_cnt_reg <= '0;
      end else if (high_cnt_reg != CW'(FILTER_CYCLES)) begin
         high_cnt_reg <= high_cnt_reg + 1'b1;
      end
   end

   // Latch holds until PWM drive is removed; a new detection wins over the clear
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         latch_reg <= 1'b0;
      end else if (high_cnt_reg == CW'(FILTER_CYCLES)) begin
         latch_reg <= 1'b1;
      end else if (!pwm_on_i) begin
         latch_reg <= 1'b0;
      end
   end

   assign fault_low_o = low_act_reg;
   assign shutdown_o  = latch_reg;

endmodule : oc_detector

// ---- logic/gain_reducer.sv ----
`timescale 1ns/1ns
// Stepped gain reduction driven by peak events and thermal warning
module gain_reducer #(
   parameter int HOLD_CYCLES   = amp_prot_pkg::AGC_HOLD_CYCLES,
   parameter int PEAKS_TO_STEP = amp_prot_pkg::AGC_PEAKS_TO_STEP
) (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic       peak_i,
   input  wire logic       thermal_warn_i,
   output logic [3:0]      step_o
);
   localparam int HW = $clog2(HOLD_CYCLES + 1);
   localparam int PW = $clog2(PEAKS_TO_STEP + 1);

   logic [HW-1:0] hold_reg;
   logic [PW-1:0] peaks_reg;
   logic [3:0]    step_reg;
   logic          peak_d_reg;
   logic          peak_rise;

   assign peak_rise = peak_i && !peak_d_reg;

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) peak_d_reg <= 1'b0;
      else peak_d_reg <= peak_i;
   end

   // Peaks counted inside a quiet window; the window restarts on each peak
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         peaks_reg <= '0;
      end else if (peak_rise) begin
         peaks_reg <= (peaks_reg == PW'(PEAKS_TO_STEP - 1)) ? '0 : peaks_reg + 1'b1;
      end else if (hold_reg == HW'(HOLD_CYCLES)) begin
         peaks_reg <= '0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || peak_rise) hold_reg <= '0;
      else if (hold_reg != HW'(HOLD_CYCLES)) hold_reg <= hold_reg + 1'b1;
   end

   // Attack one step per burst of peaks, release one step per quiet window
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         step_reg <= 4'h0;
      end else if (peak_rise && peaks_reg == PW'(PEAKS_TO_STEP - 1) && step_reg != amp_prot_pkg::AGC_MAX_STEP) begin
         step_reg <= step_reg + 4'h1;
      end else if (thermal_warn_i && step_reg < amp_prot_pkg::AGC_THERMAL_STEP) begin
         step_reg <= step_reg + 4'h1;
      end else if (hold_reg == HW'(HOLD_CYCLES - 1) && step_reg != 4'h0
                   && !(thermal_warn_i && step_reg == amp_prot_pkg::AGC_THERMAL_STEP)) begin
         step_reg <= step_reg - 4'h1;
      end
   end

   assign step_o = step_reg;

endmodule : gain_reducer

// ---- logic/amp_fault_protection_reporting.sv ----
`timescale 1ns/1ns
// Operation
// - Fault flags feed sense inputs per mode; four-half-bridge maps flag 3 onto sense 2.
// - Shared fault pin is active low, reports errors only once running.
// - During reset the shared pin is an input strapping the configuration mode.
// - Shared pin driven low while the device masters I2C during initialisation.
// - Shared pin signals the controller when a channel shuts down on high overcurrent or over-temperature while running.
// - Each stage has low and high overcurrent detectors asserting its own flag.
// - Low-threshold overcurrent asserts the flag only while it persists, unlatched.
// - High-threshold overcurrent floats the stage, latched until its PWM is turned off.
// - Overcurrent detectors filter PWM switching transients.
// - Low thermal threshold raises a warning and starts thermal management, outputs stay on.
// - High thermal threshold latches shutdown of all stages and drives all flags low.
// - Undervoltage and brownout hold the device idle until all supplies are good.
// - Supply dropping in operation shuts outputs and asserts all four flags.
// - Outputs are disabled on short, over-temperature or undervoltage events.
// - Protection response on sense inputs depends on the configured output mode.
// - Repeated peak detections step PWM gain down, tracking event timing.
// - Low thermal threshold alone makes gain reduction attenuate outputs.
module amp_fault_protection_reporting #(
   parameter int NUM_STAGES = amp_prot_pkg::NUM_STAGES,
   parameter int HOLD_CYCLES = amp_prot_pkg::AGC_HOLD_CYCLES
) (
   input  wire logic                                 clk_sys_i,
   input  wire logic                                 sys_rst_i,
   input  wire amp_prot_pkg::oc_sense_t [3:0]        oc_sense_i,
   input  wire logic [3:0]                           pwm_on_i,
   input  wire logic                                 temp_warn_i,
   input  wire logic                                 temp_crit_i,
   input  wire logic                                 supplies_ok_i,
   input  wire logic                                 init_done_i,
   input  wire logic                                 i2c_master_busy_i,
   input  wire logic                                 output_cfg_strap_lo_i,
   input  wire logic                                 output_cfg_strap_hi_i,
   input  wire logic                                 sync_cfg_strap_i,
   input  wire logic                                 shared_fault_cfg_pin_i,
   output logic                                      shared_fault_cfg_pin_o,
   output logic                                      shared_fault_cfg_pin_oe_n_o,
   output logic [3:0]                                fault_flag_n_o,
   output logic [2:0]                                sense_n_o,
   output logic [3:0]                                stage_enable_o,
   output logic [3:0]                                stage_float_o,
   output logic                                      thermal_warn_o,
   output logic [3:0]                                auto_gain_reduction_o,
   output amp_prot_pkg::out_mode_t                   out_mode_o,
   output logic                                      strap_mismatch_o
);

   amp_prot_pkg::run_state_t state_reg;
   amp_prot_pkg::run_state_t state_next;
   amp_prot_pkg::out_mode_t  mode_reg;
   logic [3:0]               low_fault;
   logic [3:0]               hi_shut;
   logic                     therm_latch_reg;
   logic [3:0]               flag_n_next;
   logic [2:0]               sense_n_next;
   logic                     any_fault;
   logic                     peak_any;
   logic [3:0]               agc_step;

   // Sense level of a flag group: any low flag faults the group
   function automatic logic group_n(input logic [3:0] flags_n, input logic [3:0] members);
      group_n = &(flags_n | ~members);
   endfunction : group_n

   for (genvar g = 0; g < 4; g++) begin : g_stage
      oc_detector u_oc (
         .clk_sys_i   (clk_sys_i),
         .sys_rst_i   (sys_rst_i),
         .sense_i     (oc_sense_i[g]),
         .pwm_on_i    (pwm_on_i[g]),
         .fault_low_o (low_fault[g]),
         .shutdown_o  (hi_shut[g])
      );
   end

   gain_reducer #(
      .HOLD_CYCLES (HOLD_CYCLES)
   ) u_agc (
      .clk_sys_i      (clk_sys_i),
      .sys_rst_i      (sys_rst_i),
      .peak_i         (peak_any),
      .thermal_warn_i (temp_warn_i && state_reg == amp_prot_pkg::ST_RUN),
      .step_o         (agc_step)
   );

   // Any routed sense input going low counts as one peak event
   assign peak_any = ~&sense_n_o;

   // Straps are resampled on every reset cycle while the shared pin is released
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         mode_reg <= amp_prot_pkg::out_mode_t'({output_cfg_strap_hi_i, output_cfg_strap_lo_i});
      end
   end

   // Only reports a bad board; the mode still follows the first strap pair
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         strap_mismatch_o <= (output_cfg_strap_hi_i != sync_cfg_strap_i)
                             || (output_cfg_strap_lo_i != shared_fault_cfg_pin_i);
      end
   end

   assign out_mode_o = mode_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         amp_prot_pkg::ST_RESET: state_next = amp_prot_pkg::ST_UVLO;
         amp_prot_pkg::ST_UVLO:  if (supplies_ok_i) state_next = amp_prot_pkg::ST_INIT;
         amp_prot_pkg::ST_INIT:  if (!supplies_ok_i) state_next = amp_prot_pkg::ST_UVLO;
                                 else if (init_done_i) state_next = amp_prot_pkg::ST_RUN;
         amp_prot_pkg::ST_RUN:   if (!supplies_ok_i) state_next = amp_prot_pkg::ST_UVLO;
         default:                state_next = amp_prot_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) state_reg <= amp_prot_pkg::ST_RESET;
      else state_reg <= state_next;
   end

   // Thermal shutdown holds until reset; cooling alone must not restart the stages
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) therm_latch_reg <= 1'b0;
      else if (temp_crit_i) therm_latch_reg <= 1'b1;
   end

   always_comb begin
      flag_n_next = ~(low_fault | hi_shut);
      if (therm_latch_reg || temp_crit_i) flag_n_next = 4'h0;
      if (state_reg == amp_prot_pkg::ST_RUN && !supplies_ok_i) flag_n_next = 4'h0;
      if (state_reg == amp_prot_pkg::ST_UVLO) flag_n_next = 4'h0;
   end

   // Routing per mode; unused sense inputs stay high
   always_comb begin
      sense_n_next = 3'h7;
      case (mode_reg)
         amp_prot_pkg::MODE_FB2,
         amp_prot_pkg::MODE_FB2_LINE: begin
            sense_n_next[0] = group_n(flag_n_next, 4'h3);
            sense_n_next[1] = group_n(flag_n_next, 4'hC);
         end
         amp_prot_pkg::MODE_HB2_SUB: begin
            sense_n_next[0] = group_n(flag_n_next, 4'h1);
            sense_n_next[1] = group_n(flag_n_next, 4'h2);
            sense_n_next[2] = group_n(flag_n_next, 4'hC);
         end
         amp_prot_pkg::MODE_HB4: begin
            sense_n_next[0] = group_n(flag_n_next, 4'h1);
            sense_n_next[1] = group_n(flag_n_next, 4'h2);
            sense_n_next[2] = group_n(flag_n_next, 4'hC);
         end
         default: sense_n_next = 3'h7;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         fault_flag_n_o <= 4'hF;
      end else begin
         fault_flag_n_o <= flag_n_next;
      end
   end

   // Registered from the same next value as the flags, so both change on one edge
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         sense_n_o <= 3'h7;
      end else begin
         sense_n_o <= sense_n_next;
      end
   end

   // Stage gating: run state only, no thermal latch, no own high-threshold fault
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         stage_enable_o <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            stage_enable_o[i] <= (state_next == amp_prot_pkg::ST_RUN) && !therm_latch_reg
                                 && !temp_crit_i && !hi_shut[i];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         stage_float_o <= 4'hF;
      end else begin
         for (int i = 0; i < 4; i++) begin
            stage_float_o[i] <= hi_shut[i] || therm_latch_reg || temp_crit_i
                                || state_next != amp_prot_pkg::ST_RUN;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         thermal_warn_o <= 1'b0;
      end else begin
         thermal_warn_o <= temp_warn_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         auto_gain_reduction_o <= 4'h0;
      end else begin
         auto_gain_reduction_o <= agc_step;
      end
   end

   assign any_fault = (|hi_shut) || therm_latch_reg || temp_crit_i;

   // Pin: released in reset, busy flag in init, channel shutdown flag when running
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         shared_fault_cfg_pin_o      <= 1'b1;
         shared_fault_cfg_pin_oe_n_o <= 1'b1;
      end else begin
         case (state_next)
            amp_prot_pkg::ST_RUN: begin
               shared_fault_cfg_pin_o      <= !any_fault;
               shared_fault_cfg_pin_oe_n_o <= 1'b0;
            end
            amp_prot_pkg::ST_INIT: begin
               shared_fault_cfg_pin_o      <= !i2c_master_busy_i;
               shared_fault_cfg_pin_oe_n_o <= 1'b0;
            end
            default: begin
               shared_fault_cfg_pin_o      <= 1'b1;
               shared_fault_cfg_pin_oe_n_o <= 1'b0;
            end
         endcase
      end
   end

endmodule : amp_fault_protection_reporting

// ---- verification/amp_fault_protection_reporting_props.sv ----
`timescale 1ns/1ns
module amp_fault_protection_reporting_props #(
   parameter int NUM_STAGES  = 4,
   parameter int HOLD_CYCLES = 50
) (
   input wire logic                          clk_sys_i,
   input wire logic                          sys_rst_i,
   input wire amp_prot_pkg::oc_sense_t [3:0] oc_sense_i,
   input wire logic [3:0]                    pwm_on_i,
   input wire logic                          temp_warn_i,
   input wire logic                          temp_crit_i,
   input wire logic                          supplies_ok_i,
   input wire logic                          init_done_i,
   input wire logic                          shared_fault_cfg_pin_o,
   input wire logic                          shared_fault_cfg_pin_oe_n_o,
   input wire logic [3:0]                    fault_flag_n_o,
   input wire logic [2:0]                    sense_n_o,
   input wire logic [3:0]                    stage_enable_o,
   input wire logic [3:0]                    stage_float_o,
   input wire logic                          thermal_warn_o,
   input wire amp_prot_pkg::out_mode_t       out_mode_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   wire logic [3:0] f = fault_flag_n_o;
   property p_hb4_route;
      out_mode_o == amp_prot_pkg::MODE_HB4 |-> sense_n_o == {f[3] & f[2], f[1], f[0]};
   endproperty
   a_hb4_route: assert property (p_hb4_route) else $error("sense routing wrong in four half-bridge mode");
   property p_fb_route;
      out_mode_o inside {amp_prot_pkg::MODE_FB2, amp_prot_pkg::MODE_FB2_LINE} && f != 4'h0
         |-> sense_n_o[1:0] == {f[3] & f[2], f[1] & f[0]};
   endproperty
   a_fb_route: assert property (p_fb_route) else $error("sense routing wrong in bridged mode");
   property p_high_hold;
      stage_float_o[1] && stage_enable_o[0] && pwm_on_i[1] |=> stage_float_o[1];
   endproperty
   a_high_hold: assert property (p_high_hold) else $error("shutdown released while drive on");
   property p_pin_fault;
      (supplies_ok_i && init_done_i)[*4] ##0 stage_float_o[1]
         |-> ##[0:2] (!shared_fault_cfg_pin_o && !shared_fault_cfg_pin_oe_n_o);
   endproperty
   a_pin_fault: assert property (p_pin_fault) else $error("shared pin not low on shutdown");
   property p_low_unlatched;
      (!oc_sense_i[2].oc_low && !oc_sense_i[2].oc_high && stage_enable_o[2] && supplies_ok_i)[*8] |-> f[2];
   endproperty
   a_low_unlatched: assert property (p_low_unlatched) else $error("flag held without overcurrent");
   // A one-cycle spike models a switching edge and must be swallowed
   property p_filter;
      (f[2] && stage_enable_o[2] && supplies_ok_i && !temp_crit_i && $rose(oc_sense_i[2].oc_low))
         ##1 (!oc_sense_i[2].oc_low && supplies_ok_i && !temp_crit_i)[*6] |-> f[2];
   endproperty
   a_filter: assert property (p_filter) else $error("spike raised a flag");
   property p_detect;
      (stage_enable_o[3] && supplies_ok_i && !temp_crit_i && oc_sense_i[3].oc_low)[*7] |-> ##[0:2] !f[3];
   endproperty
   a_detect: assert property (p_detect) else $error("overcurrent not flagged");
   property p_crit;
      temp_crit_i |-> ##[1:3] (f == 4'h0 && stage_enable_o == 4'h0);
   endproperty
   a_crit: assert property (p_crit) else $error("critical heat did not shut all stages");
   property p_uv;
      !supplies_ok_i |-> ##[1:3] (f == 4'h0 && stage_enable_o == 4'h0);
   endproperty
   a_uv: assert property (p_uv) else $error("supply loss did not shut all stages");
   property p_warn;
      $rose(temp_warn_i) && stage_enable_o == 4'hF |-> ##[1:3] (thermal_warn_o && stage_enable_o == 4'hF);
   endproperty
   a_warn: assert property (p_warn) else $error("warning missing or stages dropped");
   c_float: cover property (stage_float_o[1]);
   c_warn: cover property (thermal_warn_o);
   c_crit: cover property (temp_crit_i ##2 stage_enable_o == 4'h0);
   c_bridged: cover property (out_mode_o == amp_prot_pkg::MODE_FB2 && !sense_n_o[0]);
endmodule : amp_fault_protection_reporting_props

bind amp_fault_protection_reporting amp_fault_protection_reporting_props #(
   .NUM_STAGES(NUM_STAGES), .HOLD_CYCLES(HOLD_CYCLES)
) u_props (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .oc_sense_i(oc_sense_i), .pwm_on_i(pwm_on_i),
   .temp_warn_i(temp_warn_i), .temp_crit_i(temp_crit_i), .supplies_ok_i(supplies_ok_i),
   .init_done_i(init_done_i), .shared_fault_cfg_pin_o(shared_fault_cfg_pin_o),
   .shared_fault_cfg_pin_oe_n_o(shared_fault_cfg_pin_oe_n_o), .fault_flag_n_o(fault_flag_n_o),
   .sense_n_o(sense_n_o), .stage_enable_o(stage_enable_o), .stage_float_o(stage_float_o),
   .thermal_warn_o(thermal_warn_o), .out_mode_o(out_mode_o)
);

// ---- verification/fault_controller_model.sv ----
`timescale 1ns/1ns
module fault_controller_model (
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic       pin_o_i,
   input  wire logic       pin_oe_n_i,
   input  wire logic       pull_up_i,
   input  wire logic       ack_en_i,
   input  wire logic [3:0] fault_flag_n_i,
   output logic            pin_level_o,
   output logic [3:0]      pwm_on_o
);
   // Released pin shows the board strap resistor
   assign pin_level_o = pin_oe_n_i ? pull_up_i : pin_o_i;
   // Acknowledge by dropping drive only when told, so latching can be seen first
   always_ff @(posedge clk_sys_i) begin
      for (int i = 0; i < 4; i++) begin
         if (sys_rst_i || fault_flag_n_i[i]) pwm_on_o[i] <= 1'b1;
         else if (ack_en_i) pwm_on_o[i] <= 1'b0;
      end
   end
endmodule : fault_controller_model

// ---- verification/amp_fault_protection_reporting_tb.sv ----
`timescale 1ns/1ns
module amp_fault_protection_reporting_tb;
   logic clk_sys_i = 1'b0, sys_rst_i = 1'b1, warn = 0, crit = 0, sup = 0, idone = 0, busy = 0;
   logic slo = 1, shi = 1, ssync = 1, pull = 1, ack = 0, pin, pin_o, oe_n, twarn, mism;
   amp_prot_pkg::oc_sense_t [3:0] oc = '0;
   logic [3:0] pwm, flg, en, flt, agr;
   logic [2:0] sns;
   amp_prot_pkg::out_mode_t mode;
   int errors = 0, samples_checked = 0, cycles = 0;
   initial forever #10 clk_sys_i = ~clk_sys_i;
   amp_fault_protection_reporting #(.NUM_STAGES(4), .HOLD_CYCLES(50)) u_dut (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .oc_sense_i(oc), .pwm_on_i(pwm), .temp_warn_i(warn),
      .temp_crit_i(crit), .supplies_ok_i(sup), .init_done_i(idone), .i2c_master_busy_i(busy),
      .output_cfg_strap_lo_i(slo), .output_cfg_strap_hi_i(shi), .sync_cfg_strap_i(ssync),
      .shared_fault_cfg_pin_i(pin), .shared_fault_cfg_pin_o(pin_o), .shared_fault_cfg_pin_oe_n_o(oe_n),
      .fault_flag_n_o(flg), .sense_n_o(sns), .stage_enable_o(en), .stage_float_o(flt),
      .thermal_warn_o(twarn), .auto_gain_reduction_o(agr), .out_mode_o(mode), .strap_mismatch_o(mism));
   fault_controller_model u_ctrl (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pin_o_i(pin_o), .pin_oe_n_i(oe_n), .pull_up_i(pull),
      .ack_en_i(ack), .fault_flag_n_i(flg), .pin_level_o(pin), .pwm_on_o(pwm));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         complete_run();
      end
   end
   task automatic t_straps;
      for (int m = 0; m < 5; m++) begin
         // Last pass disagrees on the second pair, then straps settle on four half-bridge
         {shi, slo, ssync, pull} <= (m == 4) ? 4'hE : {m[1], m[0], m[1], m[0]};
         cyc(3);
         check(oe_n, 1'b1);
         check(mism, m == 4);
         if (m < 4) check(mode, m);
      end
      pull <= 1'b1;
      cyc(6);
      $display("straps done");
   endtask : t_straps
   task automatic t_power_up;
      sys_rst_i <= 1'b0;
      cyc(4);
      check(flg, 4'h0);
      check(en, 4'h0);
      sup <= 1'b1;
      busy <= 1'b1;
      cyc(4);
      check({oe_n, pin_o}, 2'b00);
      busy <= 1'b0;
      idone <= 1'b1;
      pull <= 1'b0;
      cyc(4);
      check(en, 4'hF);
      check({oe_n, pin}, 2'b01);
      $display("power up done");
   endtask : t_power_up
   task automatic t_low_oc;
      for (int k = 0; k < 5; k++) begin
         oc[3].oc_low <= 1'b1;
         cyc(10);
         check(flg, 4'h7);
         check(sns, 3'b011);
         check(en, 4'hF);
         oc[3].oc_low <= 1'b0;
         cyc(4);
         check(flg, 4'hF);
      end
      // Five bursts at four peaks per step leave exactly one step
      check(agr, 4'h1);
      oc[2].oc_low <= 1'b1;
      cyc(1);
      oc[2].oc_low <= 1'b0;
      cyc(8);
      check(flg, 4'hF);
      $display("low overcurrent done");
   endtask : t_low_oc
   task automatic t_high_oc;
      oc[1].oc_high <= 1'b1;
      cyc(10);
      oc[1].oc_high <= 1'b0;
      cyc(4);
      check({flg, en}, 8'hDD);
      check(flt, 4'h2);
      check({oe_n, pin}, 2'b00);
      ack <= 1'b1;
      cyc(8);
      ack <= 1'b0;
      check({flg, flt}, 8'hF0);
      $display("high overcurrent done");
   endtask : t_high_oc
   task automatic t_supply_heat;
      sup <= 1'b0;
      cyc(4);
      check({flg, en}, 8'h00);
      sup <= 1'b1;
      cyc(8);
      check(en, 4'hF);
      warn <= 1'b1;
      cyc(6);
      check({twarn, en}, 5'h1F);
      check(agr, amp_prot_pkg::AGC_THERMAL_STEP);
      crit <= 1'b1;
      cyc(3);
      crit <= 1'b0;
      warn <= 1'b0;
      cyc(4);
      check({flg, en}, 8'h00);
      $display("supply and heat done");
   endtask : t_supply_heat
   task automatic t_bridged;
      // Second reset re-straps the board for two bridged channels and clears the thermal latch
      sys_rst_i <= 1'b1;
      {shi, slo, ssync, pull} <= 4'h0;
      cyc(6);
      check(mode, amp_prot_pkg::MODE_FB2);
      check({mism, oe_n}, 2'b01);
      sys_rst_i <= 1'b0;
      cyc(5);
      check({flg, en}, 8'hFF);
      oc[1].oc_low <= 1'b1;
      cyc(10);
      check(flg, 4'hD);
      check(sns, 3'b110);
      oc[1].oc_low <= 1'b0;
      cyc(4);
      check(sns, 3'h7);
      $display("bridged mode done");
   endtask : t_bridged
   initial begin
      cyc(6);
      t_straps();
      t_power_up();
      t_low_oc();
      t_high_oc();
      t_supply_heat();
      t_bridged();
      complete_run();
   end
endmodule : amp_fault_protection_reporting_tb
